// file: src/bdr_params.svh
// constants for the burst dram controller with cas-before-ras refresh
// assumes a single 100 MHz clock and an external row/column address mux
// Function
// - refresh timer raises a refresh request whenever a refresh is due
// - in idle, refresh is served before a waiting access
// - pending-access flag sets when address strobe and dram select coincide
// - pending-access flag clears when last-transfer is asserted
// - access arriving during refresh or precharge is held until idle
// - idle with no refresh starts access on strobe+select or pending flag
// - idle with refresh request enters the refresh sequence
// - access: ras one cycle, column select one cycle, then strobes from byte enables
// - first strobe cycle: ready at once for write, held off for read
// - unfinished write drops strobes one cycle; last write goes to precharge
// - read: ready cycle with strobes held; loop back or precharge after last
// - precharge lasts two cycles with ras, strobes and ready off, then idle
// - refresh asserts strobes first, then ras; write strobe and ready stay off
// - refresh holds both strobes two more cycles, then two-cycle precharge
// - state counts sized for 80 ns static-column dram at a 100 MHz bus
// - refresh runs autonomously on the dram's internal row counter
`ifndef BDR_PARAMS_SVH
`define BDR_PARAMS_SVH

`define BDR_CLK_PERIOD_NS     10
`define BDR_REFRESH_NS        15000
`define BDR_REFRESH_CYCLES    (`BDR_REFRESH_NS / `BDR_CLK_PERIOD_NS)
`define BDR_REF_CNT_W         11
`define BDR_REF_CNT_ZERO      11'h000
`define BDR_BE_W              4
`define BDR_STROBES_OFF       4'h0
`define BDR_STROBES_ALL       4'hf

`endif

// file: src/bdr_pkg.sv
// types for the burst dram controller
// assumes bdr_params.svh is on the include path
package bdr_pkg;
  typedef enum logic [3:0] {
    BDR_IDLE     = 4'b0000,
    BDR_ROW      = 4'b0001,
    BDR_COL_SEL  = 4'b0010,
    BDR_STROBE   = 4'b0011,
    BDR_RD_READY = 4'b0100,
    BDR_PRE1     = 4'b0101,
    BDR_PRE2     = 4'b0110,
    BDR_REF_CAS  = 4'b0111,
    BDR_REF_RAS  = 4'b1000,
    BDR_REF_HOLD1= 4'b1001,
    BDR_REF_HOLD2= 4'b1010
  } bdr_state_t;
endpackage

// file: src/bdr_ctrl.sv
// burst static-column dram controller with cas-before-ras refresh
// assumes bus inputs arrive from the processor bus on the same clock
`include "bdr_params.svh"
module bdr_ctrl (
  input  wire logic                  SYS_CLK,
  input  wire logic                  RST,
  input  wire logic                  ADDRESS_STROBE,
  input  wire logic                  DRAM_SELECT,
  input  wire logic                  LAST_TRANSFER,
  input  wire logic                  WRITE_NOT_READ,
  input  wire logic [`BDR_BE_W-1:0]  BYTE_ENABLES,
  output logic                       ROW_STROBE,
  output logic [`BDR_BE_W-1:0]       COLUMN_STROBES,
  output logic                       COL_ADDR_SEL,
  output logic                       WRITE_STROBE,
  output logic                       READY,
  output logic                       REFRESH_REQ
);
  import bdr_pkg::*;

  // ----------------------------------------
  // state and registers
  // ----------------------------------------
  bdr_state_t                 state_reg;
  bdr_state_t                 state_next;
  logic                       access_pending_reg;
  logic [`BDR_REF_CNT_W-1:0]  ref_cnt_reg;
  logic                       ref_req_reg;

  wire new_access   = ADDRESS_STROBE && DRAM_SELECT;
  wire ref_enter    = (state_reg == BDR_IDLE) && ref_req_reg;
  wire ref_expire   = (ref_cnt_reg == `BDR_REF_CNT_ZERO);

  // the expiry cycle is one of the interval, hence the reload of one less
  wire [`BDR_REF_CNT_W-1:0] ref_reload   = `BDR_REF_CNT_W'(`BDR_REFRESH_CYCLES - 1);
  wire [`BDR_REF_CNT_W-1:0] ref_cnt_next = ref_expire ? ref_reload : ref_cnt_reg - 1'b1;

  // ----------------------------------------
  // transition conditions
  // ----------------------------------------
  // the raw strobe is looked at too, so a request met in idle costs no cycle
  wire start_access = new_access || access_pending_reg;
  wire wr_more      = WRITE_NOT_READ && !LAST_TRANSFER;
  wire wr_done      = WRITE_NOT_READ && LAST_TRANSFER;

  // ----------------------------------------
  // refresh interval timer
  // ----------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ref_cnt_reg <= `BDR_REF_CNT_ZERO;
      ref_req_reg <= 1'b0;
    end else begin
      ref_cnt_reg <= ref_cnt_next;
      if (ref_expire)
        ref_req_reg <= 1'b1;
      else if (ref_enter)
        ref_req_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // latched access request
  // ----------------------------------------
  // a new strobe wins over a same-cycle last-transfer clear
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST)
      access_pending_reg <= 1'b0;
    else if (new_access)
      access_pending_reg <= 1'b1;
    else if (LAST_TRANSFER)
      access_pending_reg <= 1'b0;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BDR_IDLE: begin
        if (ref_req_reg)
          state_next = BDR_REF_CAS;
        else if (start_access)
          state_next = BDR_ROW;
        else
          state_next = BDR_IDLE;
      end
      BDR_ROW: begin
        state_next = BDR_COL_SEL;
      end
      BDR_COL_SEL: begin
        state_next = BDR_STROBE;
      end
      BDR_STROBE: begin
        if (wr_more)
          state_next = BDR_COL_SEL;
        else if (wr_done)
          state_next = BDR_PRE1;
        else
          state_next = BDR_RD_READY;
      end
      BDR_RD_READY: begin
        if (LAST_TRANSFER)
          state_next = BDR_PRE1;
        else
          state_next = BDR_STROBE;
      end
      BDR_PRE1: begin
        state_next = BDR_PRE2;
      end
      BDR_PRE2: begin
        state_next = BDR_IDLE;
      end
      BDR_REF_CAS: begin
        state_next = BDR_REF_RAS;
      end
      BDR_REF_RAS: begin
        state_next = BDR_REF_HOLD1;
      end
      BDR_REF_HOLD1: begin
        state_next = BDR_REF_HOLD2;
      end
      BDR_REF_HOLD2: begin
        state_next = BDR_PRE1;
      end
      default: begin
        state_next = BDR_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // output table, one row per state or group of states
  // ----------------------------------------
  // state        ras  cas   col  ready   write strobe
  // idle         0    0     0    0       w/r
  // row          1    0     0    0       w/r
  // col_sel      1    0     1    0       w/r
  // strobe       1    be    1    write   w/r
  // rd_ready     1    be    1    1       w/r
  // pre1, pre2   0    0     0    0       0
  // ref_cas      0    all   0    0       0
  // ref_ras..    1    all   0    0       0
  // outputs are decoded from the next state and then registered, so each
  // output is a flip-flop and moves on the same edge as the state

  // ----------------------------------------
  // next-state decode
  // ----------------------------------------
  wire nx_row       = (state_next == BDR_ROW);
  wire nx_col_sel   = (state_next == BDR_COL_SEL);
  wire nx_strobe    = (state_next == BDR_STROBE);
  wire nx_rd_ready  = (state_next == BDR_RD_READY);
  wire nx_pre1      = (state_next == BDR_PRE1);
  wire nx_pre2      = (state_next == BDR_PRE2);
  wire nx_ref_cas   = (state_next == BDR_REF_CAS);
  wire nx_ref_ras   = (state_next == BDR_REF_RAS);
  wire nx_ref_hold1 = (state_next == BDR_REF_HOLD1);
  wire nx_ref_hold2 = (state_next == BDR_REF_HOLD2);

  wire in_access    = nx_row || nx_col_sel || nx_strobe || nx_rd_ready;
  wire in_refresh   = nx_ref_ras || nx_ref_hold1 || nx_ref_hold2;
  wire in_precharge = nx_pre1 || nx_pre2;
  wire in_strobe    = nx_strobe || nx_rd_ready;
  wire cas_all      = in_refresh || nx_ref_cas;
  wire ras_next     = in_access || in_refresh;
  wire col_next     = in_access && !nx_row;
  wire [`BDR_BE_W-1:0] cas_next = in_strobe ? BYTE_ENABLES :
                                  (cas_all ? `BDR_STROBES_ALL : `BDR_STROBES_OFF);
  wire rdy_next     = (nx_strobe && WRITE_NOT_READ) || nx_rd_ready;
  wire pre_or_ref   = cas_all || in_precharge;
  wire we_next      = pre_or_ref ? 1'b0 : WRITE_NOT_READ;

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST)
      state_reg <= BDR_IDLE;
    else
      state_reg <= state_next;
  end

  // ----------------------------------------
  // dram strobes and address mux
  // ----------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ROW_STROBE     <= 1'b0;
      COLUMN_STROBES <= `BDR_STROBES_OFF;
      COL_ADDR_SEL   <= 1'b0;
    end else begin
      ROW_STROBE     <= ras_next;
      COLUMN_STROBES <= cas_next;
      COL_ADDR_SEL   <= col_next;
    end
  end

  // ----------------------------------------
  // bus handshake and write strobe
  // ----------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      WRITE_STROBE <= 1'b0;
      READY        <= 1'b0;
    end else begin
      WRITE_STROBE <= we_next;
      READY        <= rdy_next;
    end
  end

  // ----------------------------------------
  // status
  // ----------------------------------------
  // the request level is the timer flop itself, so it needs no extra stage
  assign REFRESH_REQ = ref_req_reg;

endmodule // bdr_ctrl

// file: verification/bdr_ctrl_sva.sv
// assertions on the dram controller ports
// assumes it is bound to bdr_ctrl
module bdr_ctrl_sva (
  input wire logic       SYS_CLK,
  input wire logic       RST,
  input wire logic       LAST_TRANSFER,
  input wire logic       ROW_STROBE,
  input wire logic [3:0] COLUMN_STROBES,
  input wire logic       COL_ADDR_SEL,
  input wire logic       WRITE_STROBE,
  input wire logic       READY,
  input wire logic       REFRESH_REQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  wire ref_cas = COLUMN_STROBES == 4'hf && !ROW_STROBE;
  wire acc_row = ROW_STROBE && COLUMN_STROBES == 4'h0;
  sequence s_hold; (ROW_STROBE && COLUMN_STROBES == 4'hf)[*3]; endsequence
  sequence s_pre; (!ROW_STROBE && COLUMN_STROBES == 4'h0 && !READY)[*2]; endsequence
  a_ref_order: assert property (ref_cas |=> s_hold ##1 s_pre) else $error("bad refresh");
  a_ref_quiet: assert property (ref_cas |-> !WRITE_STROBE && !READY) else $error("refresh drives");
  a_col_after: assert property ($rose(ROW_STROBE) && acc_row |-> !COL_ADDR_SEL ##1 COL_ADDR_SEL && acc_row)
    else $error("no column select");
  a_wr_ready: assert property ($rose(ROW_STROBE) && acc_row && WRITE_STROBE |-> ##2 READY)
    else $error("write ready late");
  a_rd_ready: assert property ($rose(ROW_STROBE) && acc_row && !WRITE_STROBE |-> ##2 !READY ##1 READY)
    else $error("read ready wrong");
  a_wr_gap: assert property (READY && WRITE_STROBE && !LAST_TRANSFER |=> acc_row ##1 READY)
    else $error("write gap wrong");
  a_pre_len: assert property ($fell(ROW_STROBE) |-> s_pre) else $error("short precharge");
  a_req_drop: assert property ($fell(REFRESH_REQ) |-> ref_cas) else $error("request drop");
endmodule // bdr_ctrl_sva
bind bdr_ctrl bdr_ctrl_sva u_sva (.SYS_CLK(SYS_CLK), .RST(RST), .LAST_TRANSFER(LAST_TRANSFER),
  .ROW_STROBE(ROW_STROBE), .COLUMN_STROBES(COLUMN_STROBES), .COL_ADDR_SEL(COL_ADDR_SEL),
  .WRITE_STROBE(WRITE_STROBE), .READY(READY), .REFRESH_REQ(REFRESH_REQ));

// file: verification/bdr_bus_model.sv
// processor bus model issuing dram bursts
// assumes ready and strobes come from the controller on one clock
module bdr_bus_model (
  input  wire logic       SYS_CLK,
  input  wire logic       READY,
  input  wire logic       ROW_STROBE,
  input  wire logic       COL_ADDR_SEL,
  input  wire logic       WRITE_STROBE,
  input  wire logic [3:0] COLUMN_STROBES,
  output logic            ADDRESS_STROBE,
  output logic            DRAM_SELECT,
  output logic            LAST_TRANSFER,
  output logic            WRITE_NOT_READ,
  output logic [3:0]      BYTE_ENABLES
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {ADDRESS_STROBE, DRAM_SELECT, LAST_TRANSFER, WRITE_NOT_READ, BYTE_ENABLES} = '0;
  // last waits for the column phase so a refresh cannot cancel the pending access
  task automatic burst(input logic wr, input int beats, input logic [3:0] be, output int got, output logic ok);
    bit go;
    int n;
    got = 0;
    ok = 1'b1;
    go = 0;
    n = 0;
    @(posedge SYS_CLK);
    ADDRESS_STROBE <= 1'b1;
    DRAM_SELECT <= 1'b1;
    WRITE_NOT_READ <= wr;
    BYTE_ENABLES <= be;
    @(posedge SYS_CLK);
    ADDRESS_STROBE <= 1'b0;
    DRAM_SELECT <= 1'b0;
    while (got < beats && n < 100) begin
      @(negedge SYS_CLK);
      n++;
      if (ROW_STROBE && COL_ADDR_SEL && COLUMN_STROBES == 4'h0) go = 1;
      if (READY === 1'b1) begin
        got++;
        ok &= (COLUMN_STROBES === be) && (WRITE_STROBE === wr);
      end
      if (got < beats) @(posedge SYS_CLK) LAST_TRANSFER <= go && (beats - got == 1);
    end
    @(posedge SYS_CLK) LAST_TRANSFER <= 1'b0;
  endtask
endmodule // bdr_bus_model

// file: verification/tb_burst_dram_cbr_refresh_controller.sv
// self-checking bench for the burst dram controller
// assumes the controller, checker and bus model are compiled first
module tb_burst_dram_cbr_refresh_controller;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic as, sel, last, wnr, row, csel, we, rdy, req, ok, wr;
  logic [3:0] bew, cas, be;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  int got, n;
  always #5 SYS_CLK = ~SYS_CLK;
  bdr_ctrl u_dut (.SYS_CLK(SYS_CLK), .RST(RST), .ADDRESS_STROBE(as), .DRAM_SELECT(sel), .LAST_TRANSFER(last),
    .WRITE_NOT_READ(wnr), .BYTE_ENABLES(bew), .ROW_STROBE(row), .COLUMN_STROBES(cas), .COL_ADDR_SEL(csel),
    .WRITE_STROBE(we), .READY(rdy), .REFRESH_REQ(req));
  bdr_bus_model u_bus (.SYS_CLK(SYS_CLK), .READY(rdy), .ROW_STROBE(row), .COL_ADDR_SEL(csel), .WRITE_STROBE(we),
    .COLUMN_STROBES(cas), .ADDRESS_STROBE(as), .DRAM_SELECT(sel), .LAST_TRANSFER(last), .WRITE_NOT_READ(wnr),
    .BYTE_ENABLES(bew));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      test_done();
    end
  end
  // first burst meets the refresh after reset, the last waits for the next refresh request; the others meet precharge
  initial begin
    void'($urandom(79));
    repeat (2) @(posedge SYS_CLK);
    RST <= 1'b0;
    for (int i = 0; i < 18; i++) begin
      wr = (i == 0) ? 1'b1 : 1'($urandom);
      n = (i < 2) ? 4 : $urandom_range(4, 1);
      be = (i == 1) ? 4'hf : 4'($urandom);
      if (i == 17) begin
        while (req !== 1'b1 && cyc < 3000) @(negedge SYS_CLK);
        check("refresh_req", {7'h0, req}, 8'h01);
      end
      u_bus.burst(wr, n, be, got, ok);
      check("beats", 8'(got), 8'(n));
      check("lanes", {7'h0, ok}, 8'h01);
    end
    test_done();
  end
endmodule // tb_burst_dram_cbr_refresh_controller
